// ### hdl/mpgio_bank.sv
// Overview of operation
// RULE1 - Port A/B direction register, reset zero
// RULE2 - Direction bit: zero input, one output
// RULE3 - Port C direction register, upper bits reserved
// RULE4 - Direction acts only in GPIO function
// RULE5 - Port A/B output data register, reset zero
// RULE6 - Output bit zero low, one high
// RULE7 - Port C output data register, reserved upper
// RULE8 - Output data drives only GPIO outputs
// RULE9 - Port A/B input data register reports pins
// RULE10 - Input bit mirrors detected pin level
// RULE11 - Port C input data register reports pins
// RULE12 - Input registers read-only, pins synchronised
`include "mpgio_defines.svh"

module mpgio_bank #(
  parameter int PORT_PINS = 4
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [2:0]  hburst,
  input  wire logic [3:0]  hprot,
  input  wire logic        hmastlock,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  multipurpose_port_a_in,
  output logic      [3:0]  multipurpose_port_a_out,
  output logic      [3:0]  multipurpose_port_a_oe,
  input  wire logic [3:0]  multipurpose_port_b_in,
  output logic      [3:0]  multipurpose_port_b_out,
  output logic      [3:0]  multipurpose_port_b_oe,
  input  wire logic [3:0]  multipurpose_port_c_in,
  output logic      [3:0]  multipurpose_port_c_out,
  output logic      [3:0]  multipurpose_port_c_oe
);

  // Register fields are laid out for four pins per port only
  if (PORT_PINS != 4)
  begin : g_bad_pins
    $error("mpgio_bank: registers hold exactly four pins per port");
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  mpgio_pkg::mpgio_reg_t   ab_dir_r;
  mpgio_pkg::mpgio_reg_t   ab_out_r;
  logic [3:0]              c_dir_r;
  logic [3:0]              c_out_r;
  logic [2:0]              func_gpio_r;
  mpgio_pkg::mpgio_phase_e phase_r;
  mpgio_pkg::mpgio_phase_e phase_nxt;
  logic [7:0]              idx_r;
  logic [7:0]              idx_nxt;
  logic [11:0]             pins_sync;
  mpgio_pkg::mpgio_reg_t   rd_byte;
  logic                    addr_ok;
  logic                    wr_now;

  // ****************************************************************
  // AHB-Lite address phase capture
  // ****************************************************************
  // Index is the byte address divided by four
  assign addr_ok = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h000000);

  always_comb
  begin
    phase_nxt = mpgio_pkg::MPGIO_IDLE;
    idx_nxt   = idx_r;
    if (hsel && hready && htrans[1])
    begin
      idx_nxt   = addr_ok ? haddr[9:2] : 8'hff;
      phase_nxt = hwrite ? mpgio_pkg::MPGIO_WRITE : mpgio_pkg::MPGIO_READ;
    end
  end

  // Phase and index follow every accepted address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_r <= mpgio_pkg::MPGIO_IDLE;
      idx_r   <= 8'h00;
    end
    else
    begin
      phase_r <= phase_nxt;
      idx_r   <= idx_nxt;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_now    = (phase_r == mpgio_pkg::MPGIO_WRITE);

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  // Direction registers; reserved C bits are not stored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ab_dir_r <= `MPGIO_RST_DIR;                           // [RULE1]
      c_dir_r  <= 4'(`MPGIO_RST_DIR);                       // [RULE3]
    end
    else if (wr_now)
    begin
      if (idx_r == `MPGIO_IDX_AB_DIR)
        ab_dir_r <= hwdata[7:0];                            // [RULE1]
      if (idx_r == `MPGIO_IDX_C_DIR)
        c_dir_r <= hwdata[3:0];                             // [RULE3]
    end
  end

  // Output data registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ab_out_r <= `MPGIO_RST_OUT;                           // [RULE5]
      c_out_r  <= 4'(`MPGIO_RST_OUT);                       // [RULE7]
    end
    else if (wr_now)
    begin
      if (idx_r == `MPGIO_IDX_AB_OUT)
        ab_out_r <= hwdata[7:0];                            // [RULE5]
      if (idx_r == `MPGIO_IDX_C_OUT)
        c_out_r <= hwdata[3:0];                             // [RULE7]
    end
  end

  // Port function select: one bit per port, set means GPIO
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      func_gpio_r <= 3'(`MPGIO_RST_FUNC);
    else if (wr_now && idx_r == `MPGIO_IDX_FUNC_SEL)
      func_gpio_r <= hwdata[2:0];
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // A pin drives only when its port is GPIO and its bit says output
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      multipurpose_port_a_oe[i]  = func_gpio_r[`MPGIO_FUNC_A_BIT]
                                   && ab_dir_r[`MPGIO_AB_A_LSB + i];    // [RULE2] [RULE4]
      multipurpose_port_b_oe[i]  = func_gpio_r[`MPGIO_FUNC_B_BIT]
                                   && ab_dir_r[`MPGIO_AB_B_LSB + i];    // [RULE2] [RULE4]
      multipurpose_port_c_oe[i]  = func_gpio_r[`MPGIO_FUNC_C_BIT] && c_dir_r[i]; // [RULE4]
      // Level is gated so a stored value never reaches an idle pin
      multipurpose_port_a_out[i] = multipurpose_port_a_oe[i]
                                   && ab_out_r[`MPGIO_AB_A_LSB + i];    // [RULE6] [RULE8]
      multipurpose_port_b_out[i] = multipurpose_port_b_oe[i]
                                   && ab_out_r[`MPGIO_AB_B_LSB + i];    // [RULE6] [RULE8]
      multipurpose_port_c_out[i] = multipurpose_port_c_oe[i] && c_out_r[i]; // [RULE8]
    end
  end

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  // Pins are sampled whatever the direction, so outputs read back
  mpgio_sync #(
    .WIDTH (12)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({multipurpose_port_c_in, multipurpose_port_b_in,
                multipurpose_port_a_in}),                  // [RULE12]
    .sync_out (pins_sync)
  );

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Input registers have no write path at all
  always_comb
  begin
    case (idx_r)
      `MPGIO_IDX_AB_DIR:   rd_byte = ab_dir_r;
      `MPGIO_IDX_C_DIR:    rd_byte = {4'h0, c_dir_r};
      `MPGIO_IDX_AB_OUT:   rd_byte = ab_out_r;
      `MPGIO_IDX_C_OUT:    rd_byte = {4'h0, c_out_r};
      `MPGIO_IDX_AB_IN:    rd_byte = pins_sync[7:0];        // [RULE9] [RULE10]
      `MPGIO_IDX_C_IN:     rd_byte = {4'h0, pins_sync[11:8]}; // [RULE11] [RULE10]
      `MPGIO_IDX_FUNC_SEL: rd_byte = {5'h00, func_gpio_r};
      default:             rd_byte = 8'h00;
    endcase
  end

  // Read data registered at the address phase's end would lag pins;
  // presenting during the data phase keeps it one cycle fresh
  assign hrdata = (phase_r == mpgio_pkg::MPGIO_READ) ? {24'h000000, rd_byte} : 32'h00000000;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_DIR_RESET: assert property (@(posedge hclk)                      // [RULE1]
    $rose(hresetn) |-> ab_dir_r == 8'h00 && c_dir_r == 4'h0)
    else $error("direction not zero after reset");

  AST_NO_DRIVE_INPUT: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE2]
    !ab_dir_r[0] |-> !multipurpose_port_a_oe[0])
    else $error("input pin is driven");

  AST_C_DIR_WRITE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3]
    wr_now && idx_r == 8'h7a |=> c_dir_r == $past(hwdata[3:0]))
    else $error("port C direction write lost");

  AST_FUNC_GATE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE4]
    !func_gpio_r[2] |-> multipurpose_port_c_oe == 4'h0)
    else $error("port C driven outside GPIO");

  AST_AB_OUT_WRITE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE5]
    wr_now && idx_r == 8'h7b |=> ab_out_r == $past(hwdata[7:0]))
    else $error("port A/B output write lost");

  AST_LEVEL_HIGH: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE6]
    multipurpose_port_b_oe[3] && ab_out_r[7] |-> multipurpose_port_b_out[3])
    else $error("output one not high");

  AST_C_OUT_WRITE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE7]
    wr_now && idx_r == 8'h7c |=> c_out_r == $past(hwdata[3:0]))
    else $error("port C output write lost");

  AST_OUT_GATED: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE8]
    !multipurpose_port_a_oe[1] |-> !multipurpose_port_a_out[1])
    else $error("output level leaks to non-output pin");

  AST_AB_IN_READ: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE9]
    phase_r == mpgio_pkg::MPGIO_READ && idx_r == 8'h7d |-> hrdata[7:0] == pins_sync[7:0])
    else $error("port A/B input read wrong");

  AST_PIN_LATENCY: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE10]
    ##2 pins_sync[0] == $past(multipurpose_port_a_in[0], 2))
    else $error("pin level not reported after two cycles");

  AST_C_IN_READ: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
    phase_r == mpgio_pkg::MPGIO_READ && idx_r == 8'h7e |-> hrdata[7:4] == 4'h0)
    else $error("port C reserved bits not zero");

  AST_IN_READONLY: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE12]
    wr_now && idx_r == 8'h7d |=> $stable(ab_dir_r) && $stable(ab_out_r))
    else $error("write to input register had effect");

endmodule : mpgio_bank

// ### pkg/mpgio_defines.svh
`ifndef MPGIO_DEFINES_SVH
`define MPGIO_DEFINES_SVH

// ****************************************************************
// Register indices (printed offsets are not word multiples)
// ****************************************************************
`define MPGIO_IDX_AB_DIR   8'h79
`define MPGIO_IDX_C_DIR    8'h7a
`define MPGIO_IDX_AB_OUT   8'h7b
`define MPGIO_IDX_C_OUT    8'h7c
`define MPGIO_IDX_AB_IN    8'h7d
`define MPGIO_IDX_C_IN     8'h7e
`define MPGIO_IDX_FUNC_SEL 8'h80

// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define MPGIO_RST_DIR      8'h00
`define MPGIO_RST_OUT      8'h00
`define MPGIO_RST_FUNC     8'h00
`define MPGIO_AB_B_LSB     4
`define MPGIO_AB_A_LSB     0
`define MPGIO_FUNC_A_BIT   0
`define MPGIO_FUNC_B_BIT   1
`define MPGIO_FUNC_C_BIT   2

`endif

// ### pkg/mpgio_pkg.sv
package mpgio_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [7:0]  mpgio_reg_t;
  typedef logic [31:0] mpgio_word_t;

  // Bus slave data phase tracking, Gray coded
  typedef enum logic [1:0]
  {
    MPGIO_IDLE  = 2'b00,
    MPGIO_WRITE = 2'b01,
    MPGIO_READ  = 2'b11
  } mpgio_phase_e;

endpackage : mpgio_pkg

// ### hdl/mpgio_sync.sv
// ****************************************************************
// Two flop synchroniser, one per bit
// ****************************************************************
module mpgio_sync #(
  parameter int WIDTH = 12
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // Refuse a width that leaves nothing to synchronise
  if (WIDTH < 1)
  begin : g_bad_width
    $error("mpgio_sync: WIDTH must be at least 1");
  end

  // ****************************************************************
  // Per bit stages
  // ****************************************************************
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    logic meta_r;
    logic stable_r;
    // First stage is read only by the second stage
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        meta_r   <= 1'b0;
        stable_r <= 1'b0;
      end
      else
      begin
        meta_r   <= async_in[i];
        stable_r <= meta_r;
      end
    end
    assign sync_out[i] = stable_r;
  end

endmodule : mpgio_sync

// ### bench/mpgio_pin_model.sv
// ****************************************************************
// Far side circuitry on the twelve multipurpose pins
// ****************************************************************
module mpgio_pin_model (
  input  wire logic [11:0] oe,
  input  wire logic [11:0] drv,
  input  wire logic [11:0] ext,
  output logic      [11:0] lvl
);
  timeunit 1ns;
  timeprecision 1ps;

  // Device wins where it drives, else the outside level shows
  always_comb
  begin
    lvl = (oe & drv) | (~oe & ext);
  end
endmodule : mpgio_pin_model

// ### bench/mpgio_bank_tb.sv
`include "mpgio_defines.svh"

module mpgio_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals and reference model state
  // ****************************************************************
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [11:0] oe;
  logic [11:0] drv;
  logic [11:0] ext;
  logic [11:0] lvl;
  logic [31:0] seed;
  logic [31:0] q;
  logic [31:0] v;
  int          k;
  int          errors;
  int          total_checks;
  int          mr[5];
  int          msk[5] = '{8'hff, 8'h0f, 8'hff, 8'h0f, 8'h07};
  logic [7:0]  ids[5] = '{`MPGIO_IDX_AB_DIR, `MPGIO_IDX_C_DIR, `MPGIO_IDX_AB_OUT,
                          `MPGIO_IDX_C_OUT, `MPGIO_IDX_FUNC_SEL};

  // Free running 200 MHz clock
  always #2.5 hclk = ~hclk;

  mpgio_bank i_mpgio_bank (
    .hclk                    (hclk),
    .hresetn                 (hresetn),
    .hsel                    (hsel),
    .haddr                   (haddr),
    .htrans                  (htrans),
    .hwrite                  (hwrite),
    .hsize                   (3'h2),
    .hburst                  (3'h0),
    .hprot                   (4'h3),
    .hmastlock               (1'b0),
    .hready                  (hreadyout),
    .hwdata                  (hwdata),
    .hrdata                  (hrdata),
    .hreadyout               (hreadyout),
    .hresp                   (hresp),
    .multipurpose_port_a_in  (lvl[3:0]),
    .multipurpose_port_a_out (drv[3:0]),
    .multipurpose_port_a_oe  (oe[3:0]),
    .multipurpose_port_b_in  (lvl[7:4]),
    .multipurpose_port_b_out (drv[7:4]),
    .multipurpose_port_b_oe  (oe[7:4]),
    .multipurpose_port_c_in  (lvl[11:8]),
    .multipurpose_port_c_out (drv[11:8]),
    .multipurpose_port_c_oe  (oe[11:8])
  );

  mpgio_pin_model i_mpgio_pin_model (
    .oe  (oe),
    .drv (drv),
    .ext (ext),
    .lvl (lvl)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Single AHB transfer; waits on hready so no latency is assumed
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
    // Slave must be ready with an OKAY response in every data phase
    chk({30'h0, hreadyout, hresp}, 32'h2);
  endtask : bus

  // Pins only drive when the port is GPIO and the pin is an output
  task automatic chk_pins();
    logic [11:0] eo;
    eo = {mr[4][2] ? mr[1][3:0] : 4'h0, mr[4][1] ? mr[0][7:4] : 4'h0,
          mr[4][0] ? mr[0][3:0] : 4'h0};
    @(negedge hclk);
    chk({20'h0, oe}, {20'h0, eo});
    chk({20'h0, drv}, {20'h0, eo & {mr[3][3:0], mr[2][7:0]}});
  endtask : chk_pins

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // Main sequence: two reset rounds, random programming in each
  // ****************************************************************
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ext = 12'h0;
    seed = 32'd43465;
    errors = 0;
    total_checks = 0;
    for (int r = 0; r < 2; r++)
    begin
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      mr = '{default: 0};
      for (int i = 0; i < 5; i++)
      begin
        bus(1'b0, ids[i], 32'h0);
        chk(q, 32'h0);
      end
      chk_pins();
      repeat (30)
      begin
        v = rnd();
        k = int'(v[31:24]) % 5;
        bus(1'b1, ids[k], v);
        mr[k] = int'(v) & msk[k];
        bus(1'b0, ids[k], 32'h0);
        chk(q, mr[k]);
        chk_pins();
        v = rnd();
        // Outside levels change just after a rising edge
        @(posedge hclk);
        ext <= v[11:0];
        // Two flop synchroniser needs settling before readback
        repeat (4) @(posedge hclk);
        bus(1'b1, `MPGIO_IDX_AB_IN, ~v);
        bus(1'b0, `MPGIO_IDX_AB_IN, 32'h0);
        chk(q, {24'h0, lvl[7:0]});
        bus(1'b1, `MPGIO_IDX_C_IN, ~v);
        bus(1'b0, `MPGIO_IDX_C_IN, 32'h0);
        chk(q, {28'h0, lvl[11:8]});
      end
      bus(1'b1, 8'h7f, 32'hffff_ffff);
      bus(1'b0, 8'h7f, 32'h0);
      chk(q, 32'h0);
      chk_pins();
    end
    report_and_stop();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #(5 * 20000);
    errors++;
    report_and_stop();
  end
endmodule : mpgio_bank_tb
